// ---- design/axis_irq_regs.svh ----
// Purpose: Register offsets, field positions and reset values
// Assumes: 32-bit classic Wishbone, byte addresses, word aligned
// Notes: Axis registers are indexed by address bits 3:2
`ifndef AXIS_IRQ_REGS_SVH
`define AXIS_IRQ_REGS_SVH

`define ENABLE_BASE 8'h00
`define STATUS_BASE 8'h10
`define INTERP_CTRL_ADDR 8'h20
`define SUMMARY_STATUS_ADDR 8'h24
`define SUMMARY_MASK_ADDR 8'h28
`define ADDR_BLOCK_MASK 8'hF0

`define ENABLE_RESET 16'h0000
`define INTERP_CTRL_RESET 16'h0000
`define SUMMARY_RESET 2'h0

`define INTERP_CLEAR_BIT 0
`define INTERP_ENABLE_A_BIT 14
`define INTERP_ENABLE_B_BIT 15
`define SUMMARY_AXIS_BIT 0
`define SUMMARY_INTERP_BIT 1

`endif

// ---- design/axis_irq_pkg.sv ----
// Purpose: Types shared by the axis interrupt collector
// Assumes: Event sources run on the same clock as the collector
// Notes: Field order of the event struct matches status bits 15..0
package axis_irq_pkg;

    // One axis worth of factor levels, bit 15 first
    typedef struct packed {
        logic [3:0] paired_action_fired;
        logic split_train_done_event;
        logic split_pulse_event;
        logic timer_expired_event;
        logic home_search_done_event;
        logic drive_end_event;
        logic constant_speed_end_event;
        logic constant_speed_begin_event;
        logic drive_begin_event;
        logic [3:0] compare_hit;
    } axis_event_type;

    // Interpolation side factors and clear causes
    typedef struct packed {
        logic stack_four_to_three;
        logic stack_eight_to_seven;
        logic next_segment_written;
        logic interp_finished;
    } interp_event_type;

endpackage

// ---- design/axis_interrupt_collector.sv ----
// Purpose: Per-axis interrupt collection for a four-axis motion block
// Assumes: Factor inputs are levels from logic on clk_in
// Notes: Read-to-clear status, open-drain lines as data plus enable
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "axis_irq_regs.svh"

module axis_interrupt_collector #(
    parameter int AXES = 4
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire axis_irq_pkg::axis_event_type axis_factor_in [AXES],
    input wire axis_irq_pkg::interp_event_type interp_factor_in,
    output logic axis_irq_out_low_out,
    output logic axis_irq_out_low_oe_out,
    output logic interp_irq_out_low_out,
    output logic interp_irq_out_low_oe_out,
    output logic irq_out
);
    import axis_irq_pkg::*;

    logic [15:0] enable_reg [AXES];
    logic [15:0] enable_next [AXES];
    logic [15:0] status_reg [AXES];
    logic [15:0] status_next [AXES];
    logic [15:0] factor_prev_reg [AXES];
    logic [15:0] factor_prev_next [AXES];
    logic [15:0] new_event [AXES];
    logic [15:0] interp_ctrl_reg;
    logic [15:0] interp_ctrl_next;
    logic interp_pend_reg;
    logic interp_pend_next;
    logic [1:0] summary_reg;
    logic [1:0] summary_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic axis_line_prev_reg;
    logic interp_line_prev_reg;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic take;
    logic any_status;
    logic interp_set;
    logic interp_clear;

    // Low 16 bits of the word, honouring byte enables
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = data[7:0];
        end
        if (sel[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // Byte lanes of a status read that clear bits
    function automatic logic [15:0] lane_mask(input logic [3:0] sel);
        return {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Request taken in the cycle before ack; ack drops after one cycle
    assign take = wb_cyc_in && wb_stb_in && !ack_reg;
    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdata_reg;

    // Factor turning true is an edge, so a held level reports once
    always_comb begin
        for (int i = 0; i < AXES; i++) begin
            factor_prev_next[i] = axis_factor_in[i];
            new_event[i] = axis_factor_in[i]
                           & ~factor_prev_reg[i]
                           & enable_reg[i];
        end
    end

    // Enable and status; set wins over a read clear in the same cycle
    always_comb begin
        for (int i = 0; i < AXES; i++) begin
            enable_next[i] = enable_reg[i];
            status_next[i] = status_reg[i];
            if (take && wb_we_in &&
                wb_adr_in == (`ENABLE_BASE | 8'(i << 2))) begin
                enable_next[i] = merge16(enable_reg[i], wb_dat_in,
                                         wb_sel_in);
            end
            if (take && !wb_we_in &&
                wb_adr_in == (`STATUS_BASE | 8'(i << 2))) begin
                status_next[i] = status_reg[i]
                                 & ~lane_mask(wb_sel_in);
            end
            status_next[i] = status_next[i] | new_event[i];
        end
    end

    // Axis registers; reset leaves every factor disabled
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < AXES; i++) begin
                enable_reg[i] <= `ENABLE_RESET;
                status_reg[i] <= 16'h0000;
                factor_prev_reg[i] <= 16'hFFFF;
            end
        end else begin
            for (int i = 0; i < AXES; i++) begin
                enable_reg[i] <= enable_next[i];
                status_reg[i] <= status_next[i];
                factor_prev_reg[i] <= factor_prev_next[i];
            end
        end
    end

    // Shared line low while any bit of any axis stays set
    always_comb begin
        any_status = 1'b0;
        for (int i = 0; i < AXES; i++) begin
            any_status = any_status | (|status_reg[i]);
        end
    end
    assign axis_irq_out_low_out = 1'b0;
    assign axis_irq_out_low_oe_out = any_status;

    // Interpolation request: enabled stack factors set, three causes clear
    always_comb begin
        interp_ctrl_next = interp_ctrl_reg;
        interp_clear = interp_factor_in.next_segment_written
                       | interp_factor_in.interp_finished;
        if (take && wb_we_in && wb_adr_in == `INTERP_CTRL_ADDR) begin
            interp_ctrl_next = merge16(interp_ctrl_reg, wb_dat_in, wb_sel_in);
            interp_ctrl_next[`INTERP_CLEAR_BIT] = 1'b0; // Command, not stored
            interp_clear = interp_clear
                           | (wb_sel_in[0] && wb_dat_in[`INTERP_CLEAR_BIT]);
        end
        interp_set = (interp_factor_in.stack_four_to_three
                      && interp_ctrl_reg[`INTERP_ENABLE_A_BIT])
                     || (interp_factor_in.stack_eight_to_seven
                      && interp_ctrl_reg[`INTERP_ENABLE_B_BIT]);
        interp_pend_next = (interp_pend_reg && !interp_clear) || interp_set;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            interp_ctrl_reg <= `INTERP_CTRL_RESET;
            interp_pend_reg <= 1'b0;
        end else begin
            interp_ctrl_reg <= interp_ctrl_next;
            interp_pend_reg <= interp_pend_next;
        end
    end
    assign interp_irq_out_low_out = 1'b0;
    assign interp_irq_out_low_oe_out = interp_pend_reg;

    // Summary: line assertions latch sticky, write one to clear
    always_comb begin
        summary_next = summary_reg;
        mask_next = mask_reg;
        if (take && wb_we_in && wb_sel_in[0]) begin
            if (wb_adr_in == `SUMMARY_STATUS_ADDR) begin
                summary_next = summary_reg & ~wb_dat_in[1:0];
            end
            if (wb_adr_in == `SUMMARY_MASK_ADDR) begin
                mask_next = wb_dat_in[1:0];
            end
        end
        // Set after the clear so a same-cycle event is kept
        if (any_status && !axis_line_prev_reg) begin
            summary_next[`SUMMARY_AXIS_BIT] = 1'b1;
        end
        if (interp_pend_reg && !interp_line_prev_reg) begin
            summary_next[`SUMMARY_INTERP_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            summary_reg <= `SUMMARY_RESET;
            mask_reg <= `SUMMARY_RESET;
            axis_line_prev_reg <= 1'b0;
            interp_line_prev_reg <= 1'b0;
        end else begin
            summary_reg <= summary_next;
            mask_reg <= mask_next;
            axis_line_prev_reg <= any_status;
            interp_line_prev_reg <= interp_pend_reg;
        end
    end
    assign irq_out = |(summary_reg & mask_reg);

    // Bus answer; enable reads as zero since it is write-only
    always_comb begin
        ack_next = take;
        rdata_next = rdata_reg;
        if (take) begin
            rdata_next = 32'h0000_0000;
            if (!wb_we_in) begin
                for (int i = 0; i < AXES; i++) begin
                    if (wb_adr_in == (`STATUS_BASE | 8'(i << 2))) begin
                        rdata_next[15:0] = status_reg[i]
                                           & lane_mask(wb_sel_in);
                    end
                end
                if (wb_adr_in == `INTERP_CTRL_ADDR) begin
                    rdata_next[15:0] = interp_ctrl_reg;
                    rdata_next[16] = interp_pend_reg;
                end
                if (wb_adr_in == `SUMMARY_STATUS_ADDR) begin
                    rdata_next[1:0] = summary_reg;
                end
                if (wb_adr_in == `SUMMARY_MASK_ADDR) begin
                    rdata_next[1:0] = mask_reg;
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // Checks on axis 0, the interpolation line and the bus ack
    a_reset_enables_clear: assert property (
        @(posedge clk_in) $fell(reset_in) |-> enable_reg[0] == 16'h0000
            && !interp_ctrl_reg[`INTERP_ENABLE_A_BIT])
        else $error("enable not cleared by reset");

    a_event_sets_status: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (new_event[0] != 16'h0000) |=>
            axis_irq_out_low_oe_out
            && (status_reg[0] & $past(new_event[0])) == $past(new_event[0]))
        else $error("enabled event did not set status");

    a_disabled_no_set: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ##1 ((status_reg[0] & ~$past(status_reg[0]))
             & ~$past(enable_reg[0])) == 16'h0000)
        else $error("disabled factor set status");

    a_read_clears: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (take && !wb_we_in && wb_adr_in == `STATUS_BASE
         && wb_sel_in[1:0] == 2'b11 && new_event[0] == 16'h0000)
        |=> status_reg[0] == 16'h0000 ##1 wb_ack_out == 1'b0)
        else $error("status read did not clear");

    a_lane_keeps_other: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (take && !wb_we_in && wb_adr_in == `STATUS_BASE
         && wb_sel_in[1:0] == 2'b01)
        |=> (status_reg[0][15:8] & $past(status_reg[0][15:8]))
            == $past(status_reg[0][15:8]))
        else $error("low lane read touched high byte");

    a_other_read_keeps: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (take && !wb_we_in
         && (wb_adr_in & `ADDR_BLOCK_MASK) != `STATUS_BASE)
        |=> (status_reg[0] & $past(status_reg[0])) == $past(status_reg[0]))
        else $error("non-status read cleared status");

    a_first_read_only: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (take && !wb_we_in && wb_adr_in == `STATUS_BASE
         && wb_sel_in[1:0] == 2'b11 && new_event[0] == 16'h0000)
        ##1 (new_event[0] == 16'h0000) [*2]
        ##1 (take && !wb_we_in && wb_adr_in == `STATUS_BASE)
        |=> wb_dat_out[15:0] == 16'h0000)
        else $error("event reported twice");

    a_interp_line: assert property (
        @(posedge clk_in) disable iff (reset_in)
        interp_set |=> interp_irq_out_low_oe_out && !interp_irq_out_low_out)
        else $error("interpolation request not raised");

    a_ack_single: assert property (
        @(posedge clk_in) disable iff (reset_in)
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held two cycles");

endmodule

// ---- testbench/event_source_model.sv ----
// Purpose: Axis and interpolation factor sources for the collector
// Assumes: Same clock as the collector, levels active high
// Notes: Each fire gives a one-cycle high level, then back to low
`timescale 1ns/1ps

module event_source_model (
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic [1:0] axis_sel_in,
    input wire logic [15:0] bits_in,
    input wire logic [3:0] interp_bits_in,
    output axis_irq_pkg::axis_event_type axis_factor_out [4],
    output axis_irq_pkg::interp_event_type interp_factor_out
);
    import axis_irq_pkg::*;

    // Short pulses, so every fire is a fresh 0 to 1 change
    always_ff @(posedge clk_in) begin
        for (int a = 0; a < 4; a++) begin
            axis_factor_out[a] <= (fire_in && axis_sel_in == 2'(a)) ?
                axis_event_type'(bits_in) : '0;
        end
        interp_factor_out <= fire_in ?
            interp_event_type'(interp_bits_in) : '0;
    end
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the axis interrupt collector
// Assumes: Classic Wishbone master tasks, one 250 MHz clock
// Notes: Request lines seen through a pull-up, high when released
`timescale 1ns/1ps
`include "axis_irq_regs.svh"

`define CHK(got, exp) begin samples_checked++; \
    if ((got) !== (exp)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, got, exp); end end

module tb_top;
    import axis_irq_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic ack;
    logic fire_req = 1'b0;
    logic [1:0] ax_sel = 2'h0;
    logic [15:0] ev_bits = 16'h0;
    logic [3:0] ip_bits = 4'h0;
    axis_event_type factors [4];
    interp_event_type ifactors;
    logic ax_d, ax_oe, ip_d, ip_oe, irq_out;
    int failures = 0;
    int samples_checked = 0;
    // Open-drain lines resolved against a pull-up
    wire ax_line = ax_oe ? ax_d : 1'b1;
    wire ip_line = ip_oe ? ip_d : 1'b1;

    axis_interrupt_collector dut (.clk_in(clk_in), .reset_in(reset_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
        .wb_ack_out(ack), .axis_factor_in(factors),
        .interp_factor_in(ifactors), .axis_irq_out_low_out(ax_d),
        .axis_irq_out_low_oe_out(ax_oe), .interp_irq_out_low_out(ip_d),
        .interp_irq_out_low_oe_out(ip_oe), .irq_out(irq_out));

    event_source_model src (.clk_in(clk_in), .fire_in(fire_req),
        .axis_sel_in(ax_sel), .bits_in(ev_bits),
        .interp_bits_in(ip_bits), .axis_factor_out(factors),
        .interp_factor_out(ifactors));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    // Request held until ack is sampled, then released for a cycle
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_w <= d;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        `CHK(ack, 1'b1)
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, s, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [3:0] s,
                          input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, s, 32'h0, q);
        `CHK(q, e)
    endtask

    task automatic fire(input logic [1:0] a, input logic [15:0] b,
                        input logic [3:0] i);
        @(posedge clk_in);
        fire_req <= 1'b1;
        ax_sel <= a;
        ev_bits <= b;
        ip_bits <= i;
        @(posedge clk_in);
        fire_req <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic lines(input logic ax, input logic ip);
        `CHK(ax_line, ax)
        `CHK(ip_line, ip)
    endtask

    task automatic close_out();
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        logic [15:0] m;
        logic [7:0] sa;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        // Every factor fired before any enable is written
        for (int a = 0; a < 4; a++) begin
            fire(2'(a), 16'hFFFF, 4'hF);
            lines(1'b1, 1'b1);
            rd_chk(`STATUS_BASE + 8'(4 * a), 4'hF, 32'h0);
        end
        // One enabled bit per pass, all factors fired together
        for (int a = 0; a < 4; a++) begin
            for (int b = 0; b < 16; b++) begin
                m = 16'h1 << b;
                sa = `STATUS_BASE + 8'(4 * a);
                wr(`ENABLE_BASE + 8'(4 * a), 4'hF, {16'h0, m});
                fire(2'(a), 16'hFFFF, 4'h0);
                lines(1'b0, 1'b1);
                rd_chk(sa, 4'hF, {16'h0, m});
                lines(1'b1, 1'b1);
                rd_chk(sa, 4'hF, 32'h0);
            end
        end
        // Mid-run reset must drop the enables written above
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        fire(2'd3, 16'hFFFF, 4'h0);
        lines(1'b1, 1'b1);
        rd_chk(`STATUS_BASE + 8'h0C, 4'hF, 32'h0);
        // Two events pile up; other reads leave them; lanes clear apart
        wr(`ENABLE_BASE, 4'hF, 32'hFFFF);
        fire(2'd0, 16'h0101, 4'h0);
        fire(2'd0, 16'h8000, 4'h0);
        rd_chk(`ENABLE_BASE, 4'hF, 32'h0);
        rd_chk(8'h3C, 4'hF, 32'h0);
        lines(1'b0, 1'b1);
        rd_chk(`STATUS_BASE, 4'h1, 32'h01);
        lines(1'b0, 1'b1);
        rd_chk(`STATUS_BASE, 4'h2, 32'h8100);
        lines(1'b1, 1'b1);
        // Summary interrupt: raise, mask, unmask, clear
        wr(`SUMMARY_MASK_ADDR, 4'hF, 32'h1);
        wr(`SUMMARY_STATUS_ADDR, 4'hF, 32'h3);
        `CHK(irq_out, 1'b0)
        fire(2'd0, 16'h0010, 4'h0);
        `CHK(irq_out, 1'b1)
        rd_chk(`STATUS_BASE, 4'hF, 32'h0010);
        `CHK(irq_out, 1'b1)
        wr(`SUMMARY_MASK_ADDR, 4'hF, 32'h0);
        `CHK(irq_out, 1'b0)
        wr(`SUMMARY_MASK_ADDR, 4'hF, 32'h1);
        `CHK(irq_out, 1'b1)
        wr(`SUMMARY_STATUS_ADDR, 4'hF, 32'h1);
        `CHK(irq_out, 1'b0)
        // Interpolation line: both set causes, all three clear causes
        wr(`INTERP_CTRL_ADDR, 4'hF, 32'hC000);
        for (int k = 0; k < 3; k++) begin
            fire(2'd0, 16'h0, k[0] ? 4'h8 : 4'h4);
            lines(1'b1, 1'b0);
            if (k == 0) begin
                rd_chk(`INTERP_CTRL_ADDR, 4'hF, 32'h0001_C000);
                wr(`INTERP_CTRL_ADDR, 4'hF, 32'hC001);
            end else begin
                fire(2'd0, 16'h0, (k == 1) ? 4'h2 : 4'h1);
            end
            lines(1'b1, 1'b1);
        end
        // Interpolation bit of the summary latched during the loop
        rd_chk(`SUMMARY_STATUS_ADDR, 4'hF, 32'h2);
        wr(`SUMMARY_MASK_ADDR, 4'hF, 32'h2);
        rd_chk(`SUMMARY_MASK_ADDR, 4'hF, 32'h2);
        `CHK(irq_out, 1'b1)
        wr(`SUMMARY_STATUS_ADDR, 4'hF, 32'h2);
        `CHK(irq_out, 1'b0)
        close_out();
    end
endmodule
